// ===== hw/link_align_pkg.sv
// constants and types shared by the 7:1 link alignment design
package link_align_pkg;
  localparam int CLK_NS = 25;
  localparam int BIT_NS = 100;
  localparam int BIT_CYCLES = (BIT_NS / CLK_NS) < 1 ? 1 : (BIT_NS / CLK_NS);
  localparam int WORD_BITS = 7;
  localparam int LANES = 4;
  localparam logic [6:0] PHASE_PATTERN = 7'h0f;
  localparam logic [6:0] WORD_PATTERN = 7'h01;
  localparam logic [6:0] IDLE_WORD = 7'h00;
  localparam logic [2:0] LOCK_WORDS = 3'h4;
  localparam logic [1:0] SLIP_SETTLE = 2'h2;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] INT_STATUS_OFF = 8'h08;
  localparam logic [7:0] INT_MASK_OFF = 8'h0c;
  localparam logic [7:0] MISMATCH_OFF = 8'h10;
  localparam int CTRL_GEN_EN_BIT = 0;
  localparam int CTRL_RETRAIN_BIT = 1;
  localparam logic CTRL_GEN_EN_RESET = 1'b1;
  localparam int ST_PHASE_BIT = 0;
  localparam int ST_WORD_BIT = 1;
  localparam int ST_TRAINED_BIT = 2;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_SLIPS_LSB = 8;
  localparam int INT_W = 3;
  localparam int EV_TRAINED_BIT = 0;
  localparam int EV_LOCK_BIT = 1;
  localparam int EV_LOSS_BIT = 2;
  localparam logic [2:0] INT_RESET = 3'h0;
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_PHASE = 2'b01,
    SRC_WORD = 2'b10,
    SRC_COUNT = 2'b11
  } src_mode_t;
endpackage

// ===== hw/tx_serializer.sv
// seven-to-one serializer for all lanes plus forwarded serial bit clock
`timescale 1ns/10ps
`default_nettype none
module tx_serializer #(
  parameter int LANES = 4,
  parameter int WORD_BITS = 7,
  parameter int BIT_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LANES*WORD_BITS-1:0] word_in,
  output logic word_take,
  output logic serial_bit_clock,
  output logic [LANES-1:0] lane_out
);
  logic [7:0] div_ff, nxt_div;
  logic [2:0] bit_ff, nxt_bit;
  logic clk_ff, nxt_clk;
  logic take_ff, nxt_take;
  logic tick;
  logic last_bit;

  assign tick = (div_ff == 8'(BIT_CYCLES - 1));
  assign last_bit = (bit_ff == 3'(WORD_BITS - 1));

  always_comb begin
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_bit = bit_ff;
    nxt_clk = clk_ff;
    nxt_take = 1'b0;
    if (tick) begin
      // one bit per half period: data moves on both clock edges [RULE5]
      nxt_clk = ~clk_ff;
      nxt_bit = last_bit ? 3'h0 : bit_ff + 3'h1; // seven bits per word [RULE3]
      nxt_take = last_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h00;
      bit_ff <= 3'h0;
      clk_ff <= 1'b0;
      take_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      clk_ff <= nxt_clk;
      take_ff <= nxt_take;
    end
  end

  assign serial_bit_clock = clk_ff;
  assign word_take = take_ff;

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [WORD_BITS-1:0] sh_ff, nxt_sh;
      always_comb begin
        nxt_sh = sh_ff;
        if (tick) begin
          // msb first; new word loaded as the last bit of the old one ends
          nxt_sh = last_bit ? word_in[l*WORD_BITS +: WORD_BITS] : {sh_ff[WORD_BITS-2:0], 1'b0};
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sh_ff <= '0;
        end else begin
          sh_ff <= nxt_sh;
        end
      end
      assign lane_out[l] = sh_ff[WORD_BITS-1]; // same clock source as the forwarded clock [RULE4]
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hw/rx_deserializer.sv
// one-lane serial to seven-bit word converter with bit slip
`timescale 1ns/10ps
`default_nettype none
module rx_deserializer #(
  parameter int WORD_BITS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_in,
  input wire logic bit_strobe,
  input wire logic slip,
  output logic [WORD_BITS-1:0] word_out,
  output logic word_valid
);
  logic [WORD_BITS-1:0] sh_ff, nxt_sh;
  logic [WORD_BITS-1:0] word_ff, nxt_word;
  logic [2:0] cnt_ff, nxt_cnt;
  logic valid_ff, nxt_valid;
  logic slip_ff, nxt_slip;

  always_comb begin
    nxt_sh = sh_ff;
    nxt_word = word_ff;
    nxt_cnt = cnt_ff;
    nxt_valid = 1'b0;
    // slip may arrive between bits, so it waits for the next one
    nxt_slip = slip_ff | slip;
    if (bit_strobe) begin
      nxt_sh = {sh_ff[WORD_BITS-2:0], bit_in};
      if (slip_ff) begin
        nxt_slip = slip;
      end else if (cnt_ff == 3'(WORD_BITS - 1)) begin
        nxt_cnt = 3'h0;
        nxt_word = nxt_sh; // 7-bit parallel word [RULE7]
        nxt_valid = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff <= '0;
      word_ff <= '0;
      cnt_ff <= 3'h0;
      valid_ff <= 1'b0;
      slip_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      word_ff <= nxt_word;
      cnt_ff <= nxt_cnt;
      valid_ff <= nxt_valid;
      slip_ff <= nxt_slip;
    end
  end

  assign word_out = word_ff;
  assign word_valid = valid_ff;
endmodule
`default_nettype wire

// ===== hw/lvds_link_align.sv
// 7:1 link: pattern source, serializer, receiver alignment, checker, apb registers
//
// Notes on behaviour
// [RULE1] The transmitter sends the phase pattern, then the word pattern, then an incrementing counter on all lanes.
// [RULE2] The serial bit clock runs at 3.5 times the word rate, since a word spans seven half periods.
// [RULE3] Each word of seven bits per lane fills exactly one word period of the forwarded clock.
// [RULE4] The output is one forwarded clock pair and four data pairs, all from one clock source.
// [RULE5] Serial data change on both edges of the serial bit clock.
// [RULE6] The receiver takes the forwarded clock with the lanes and recovers every lane on its edges.
// [RULE7] Each lane is presented as a 7-bit word and alignment is judged on that word.
// [RULE8] A lane gets bit-slip pulses until its words equal the phase pattern.
// [RULE9] Once all lanes are phase aligned the source switches to the word pattern.
// [RULE10] With phase and word alignment reached, read enable goes high and lets the counter source advance.
// [RULE11] Data checking starts only after word alignment is flagged.
// [RULE12] Training done goes high once words are both phase and word aligned.
// [RULE13] Data lock is high while received counter words equal what was sent.
// [RULE14] The pattern generation enable input must be high for any patterns or data to be sent.
// [RULE15] Serial and word timing are derived from the block's reference clock by division.
// [RULE16] The phase and word patterns are fixed, distinct, and unambiguous under rotation.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lvds_link_align #(
  parameter int LANES = link_align_pkg::LANES,
  parameter int WORD_BITS = link_align_pkg::WORD_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [link_align_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_en,
  input wire logic rx_clk_p,
  input wire logic [LANES-1:0] rx_data_p,
  output logic tx_clk_p,
  output logic tx_clk_n,
  output logic [LANES-1:0] tx_data_p,
  output logic [LANES-1:0] tx_data_n,
  output logic training_done,
  output logic data_lock,
  output logic irq
);
  localparam int WB = LANES * WORD_BITS;

  // all lanes carry the same word once trained
  function automatic logic lanes_equal(input logic [WB-1:0] w, input logic [WORD_BITS-1:0] v);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      if (w[i*WORD_BITS +: WORD_BITS] != v) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction

  // ---- input synchronisers: clock pin, data pins, enable pin ----
  logic [LANES+1:0] s1_ff, s2_ff, s3_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {data_en, rx_clk_p, rx_data_p};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  logic en_pin;
  logic rx_edge;
  logic [LANES-1:0] rx_bits;
  assign en_pin = s2_ff[LANES+1];
  // data and clock change together; the older copy holds the settled bit [RULE6]
  assign rx_edge = s2_ff[LANES] ^ s3_ff[LANES];
  assign rx_bits = s3_ff[LANES-1:0];

  // ---- registers ----
  logic gen_en_ff, nxt_gen_en;
  logic retrain_ff, nxt_retrain;
  logic [2:0] int_st_ff, nxt_int_st;
  logic [2:0] int_mask_ff, nxt_int_mask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  logic [15:0] mism_ff, nxt_mism;
  logic [7:0] slips_ff, nxt_slips;

  logic gen_en;
  logic restart;
  // pattern source runs only with both the pin and the software enable [RULE14]
  assign gen_en = en_pin & gen_en_ff;
  assign restart = retrain_ff | ~gen_en;

  // ---- transmit side ----
  link_align_pkg::src_mode_t mode;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [WORD_BITS-1:0] src_word;
  logic word_take;
  logic ser_clk;
  logic [LANES-1:0] ser_out;
  logic phase_locked;
  logic word_aligned;
  logic rd_en_ff, nxt_rd_en;

  always_comb begin
    if (!gen_en) begin
      mode = link_align_pkg::SRC_IDLE;
    end else if (!phase_locked) begin
      mode = link_align_pkg::SRC_PHASE; // [RULE1]
    end else if (!rd_en_ff) begin
      mode = link_align_pkg::SRC_WORD; // [RULE9]
    end else begin
      mode = link_align_pkg::SRC_COUNT; // [RULE1]
    end
  end

  always_comb begin
    unique case (mode)
      link_align_pkg::SRC_IDLE: src_word = link_align_pkg::IDLE_WORD;
      link_align_pkg::SRC_PHASE: src_word = link_align_pkg::PHASE_PATTERN; // [RULE16]
      link_align_pkg::SRC_WORD: src_word = link_align_pkg::WORD_PATTERN; // [RULE16]
      link_align_pkg::SRC_COUNT: src_word = cnt_ff;
    endcase
    // counter only advances while the receiver's read enable is high [RULE10]
    nxt_cnt = (mode == link_align_pkg::SRC_COUNT && word_take) ? cnt_ff + 7'h01 : cnt_ff;
    if (mode != link_align_pkg::SRC_COUNT) begin
      nxt_cnt = 7'h00;
    end
  end

  // bit period is a division of the reference clock [RULE15] [RULE2]
  tx_serializer #(
    .LANES(LANES),
    .WORD_BITS(WORD_BITS),
    .BIT_CYCLES(link_align_pkg::BIT_CYCLES)
  ) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .word_in({LANES{src_word}}),
    .word_take(word_take),
    .serial_bit_clock(ser_clk),
    .lane_out(ser_out)
  );

  // complementary legs of each pair [RULE4]
  assign tx_clk_p = ser_clk;
  assign tx_clk_n = ~ser_clk;
  assign tx_data_p = ser_out;
  assign tx_data_n = ~ser_out;

  // ---- receive side ----
  logic [WB-1:0] rx_word;
  logic [LANES-1:0] rx_valid;
  logic [LANES-1:0] slip;
  logic [2:0] match_ff [LANES], nxt_match [LANES];
  logic [1:0] settle_ff [LANES], nxt_settle [LANES];
  logic [LANES-1:0] phase_ok_ff, nxt_phase_ok;
  logic [LANES-1:0] seen_ff, nxt_seen;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_rx
      rx_deserializer #(
        .WORD_BITS(WORD_BITS)
      ) u_des (
        .pclk(pclk),
        .presetn(presetn),
        .bit_in(rx_bits[g]),
        .bit_strobe(rx_edge),
        .slip(slip[g]),
        .word_out(rx_word[g*WORD_BITS +: WORD_BITS]),
        .word_valid(rx_valid[g])
      );
    end
  endgenerate

  always_comb begin
    slip = '0;
    nxt_phase_ok = phase_ok_ff;
    nxt_seen = seen_ff;
    for (int l = 0; l < LANES; l++) begin
      nxt_match[l] = match_ff[l];
      nxt_settle[l] = settle_ff[l];
      if (restart) begin
        nxt_match[l] = 3'h0;
        nxt_settle[l] = 2'h0;
        nxt_phase_ok[l] = 1'b0;
        nxt_seen[l] = 1'b0;
      end else if (rx_valid[l] && !phase_ok_ff[l]) begin
        if (settle_ff[l] != 2'h0) begin
          // the next two words, framed after the slip took effect, are ignored
          nxt_settle[l] = settle_ff[l] - 2'h1;
        end else if (rx_word[l*WORD_BITS +: WORD_BITS] == link_align_pkg::PHASE_PATTERN) begin
          nxt_match[l] = match_ff[l] + 3'h1; // [RULE7]
          nxt_phase_ok[l] = (match_ff[l] == link_align_pkg::LOCK_WORDS - 3'h1);
        end else begin
          slip[l] = 1'b1; // [RULE8]
          nxt_match[l] = 3'h0;
          nxt_settle[l] = link_align_pkg::SLIP_SETTLE;
        end
      end else if (rx_valid[l] && rx_word[l*WORD_BITS +: WORD_BITS] == link_align_pkg::WORD_PATTERN) begin
        nxt_seen[l] = 1'b1;
      end
    end
  end

  assign phase_locked = &phase_ok_ff;
  assign word_aligned = &seen_ff;
  assign nxt_rd_en = phase_locked & word_aligned & ~restart; // [RULE10] [RULE12]
  assign training_done = rd_en_ff; // [RULE12]
  assign nxt_slips = restart ? 8'h00 : slips_ff + {7'h00, |slip};

  // ---- data checker ----
  logic armed_ff, nxt_armed;
  logic [6:0] expect_ff, nxt_expect;
  logic lock_ff, nxt_lock;
  logic [6:0] w0;
  assign w0 = rx_word[WORD_BITS-1:0];

  always_comb begin
    nxt_armed = armed_ff;
    nxt_expect = expect_ff;
    nxt_lock = lock_ff;
    nxt_mism = mism_ff;
    if (!rd_en_ff) begin
      // no checking before word alignment is flagged [RULE11]
      nxt_armed = 1'b0;
      nxt_lock = 1'b0;
    end else if (rx_valid[0]) begin
      if (!armed_ff) begin
        if (w0 != link_align_pkg::WORD_PATTERN && lanes_equal(rx_word, w0)) begin
          nxt_armed = 1'b1;
          nxt_expect = w0 + 7'h01;
          nxt_lock = 1'b1;
        end
      end else begin
        // resync on lane 0's received value so a bad word costs at most two words
        nxt_lock = lanes_equal(rx_word, expect_ff); // [RULE13]
        nxt_expect = w0 + 7'h01;
        if (!nxt_lock) begin
          nxt_mism = mism_ff + 16'h0001;
        end
      end
    end
    if (restart) begin
      nxt_mism = 16'h0000;
    end
  end
  assign data_lock = lock_ff;

  // ---- apb slave, zero wait states ----
  logic wr;
  logic rd_setup;
  logic hit;
  logic [2:0] ev;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit = paddr == link_align_pkg::CTRL_OFF || paddr == link_align_pkg::STATUS_OFF
    || paddr == link_align_pkg::INT_STATUS_OFF || paddr == link_align_pkg::INT_MASK_OFF
    || paddr == link_align_pkg::MISMATCH_OFF;

  always_comb begin
    ev = '0;
    ev[link_align_pkg::EV_TRAINED_BIT] = nxt_rd_en & ~rd_en_ff;
    ev[link_align_pkg::EV_LOCK_BIT] = nxt_lock & ~lock_ff;
    ev[link_align_pkg::EV_LOSS_BIT] = ~nxt_lock & lock_ff;
    nxt_gen_en = gen_en_ff;
    nxt_retrain = 1'b0;
    nxt_int_mask = int_mask_ff;
    nxt_int_st = int_st_ff;
    if (wr && paddr == link_align_pkg::CTRL_OFF) begin
      nxt_gen_en = pwdata[link_align_pkg::CTRL_GEN_EN_BIT];
      nxt_retrain = pwdata[link_align_pkg::CTRL_RETRAIN_BIT];
    end
    if (wr && paddr == link_align_pkg::INT_MASK_OFF) begin
      nxt_int_mask = pwdata[2:0];
    end
    if (wr && paddr == link_align_pkg::INT_STATUS_OFF) begin
      nxt_int_st = int_st_ff & ~pwdata[2:0];
    end
    // a new event beats a clear in the same cycle
    nxt_int_st = nxt_int_st | ev;
    nxt_rdata = rdata_ff;
    nxt_err = psel & ~hit;
    if (rd_setup) begin
      nxt_rdata = 32'h0000_0000;
      unique case (1'b1)
        paddr == link_align_pkg::CTRL_OFF: nxt_rdata[link_align_pkg::CTRL_GEN_EN_BIT] = gen_en_ff;
        paddr == link_align_pkg::STATUS_OFF: begin
          nxt_rdata[link_align_pkg::ST_PHASE_BIT] = phase_locked;
          nxt_rdata[link_align_pkg::ST_WORD_BIT] = word_aligned;
          nxt_rdata[link_align_pkg::ST_TRAINED_BIT] = rd_en_ff;
          nxt_rdata[link_align_pkg::ST_LOCK_BIT] = lock_ff;
          nxt_rdata[link_align_pkg::ST_SLIPS_LSB +: 8] = slips_ff;
        end
        paddr == link_align_pkg::INT_STATUS_OFF: nxt_rdata[2:0] = int_st_ff;
        paddr == link_align_pkg::INT_MASK_OFF: nxt_rdata[2:0] = int_mask_ff;
        paddr == link_align_pkg::MISMATCH_OFF: nxt_rdata[15:0] = mism_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = err_ff & psel & penable;
  assign irq = |(int_st_ff & int_mask_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_en_ff <= link_align_pkg::CTRL_GEN_EN_RESET;
      retrain_ff <= 1'b0;
      int_st_ff <= link_align_pkg::INT_RESET;
      int_mask_ff <= link_align_pkg::INT_RESET;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      mism_ff <= 16'h0000;
      slips_ff <= 8'h00;
      cnt_ff <= 7'h00;
      rd_en_ff <= 1'b0;
      phase_ok_ff <= '0;
      seen_ff <= '0;
      armed_ff <= 1'b0;
      expect_ff <= 7'h00;
      lock_ff <= 1'b0;
      for (int l = 0; l < LANES; l++) begin
        match_ff[l] <= 3'h0;
        settle_ff[l] <= 2'h0;
      end
    end else begin
      gen_en_ff <= nxt_gen_en;
      retrain_ff <= nxt_retrain;
      int_st_ff <= nxt_int_st;
      int_mask_ff <= nxt_int_mask;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
      mism_ff <= nxt_mism;
      slips_ff <= nxt_slips;
      cnt_ff <= nxt_cnt;
      rd_en_ff <= nxt_rd_en;
      phase_ok_ff <= nxt_phase_ok;
      seen_ff <= nxt_seen;
      armed_ff <= nxt_armed;
      expect_ff <= nxt_expect;
      lock_ff <= nxt_lock;
      for (int l = 0; l < LANES; l++) begin
        match_ff[l] <= nxt_match[l];
        settle_ff[l] <= nxt_settle[l];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/link_peer.sv
// loopback far end: returns the forwarded clock and lanes after a wire delay
`timescale 1ns/10ps
`default_nettype none
module link_peer #(
  parameter int LANES = 4,
  parameter real DELAY_NS = 7.0
) (
  input wire logic tx_clk,
  input wire logic [LANES-1:0] tx_data,
  input wire logic flip,
  output logic rx_clk,
  output logic [LANES-1:0] rx_data
);
  // odd delay keeps the returned clock off the pclk grid
  assign #(DELAY_NS) rx_clk = tx_clk;
  // flip spoils lane 0 only while the bench asks for it
  assign #(DELAY_NS) rx_data = tx_data ^ LANES'(flip);
endmodule
`default_nettype wire

// ===== sim/lvds_link_align_assertions.sv
// port checks for the 7:1 link alignment block
`timescale 1ns/10ps
`default_nettype none
module lvds_link_align_chk #(
  parameter int LANES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [link_align_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic data_en,
  input wire logic rx_clk_p,
  input wire logic [LANES-1:0] rx_data_p,
  input wire logic tx_clk_p,
  input wire logic tx_clk_n,
  input wire logic [LANES-1:0] tx_data_p,
  input wire logic [LANES-1:0] tx_data_n,
  input wire logic training_done,
  input wire logic data_lock,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles with the enable pin low, saturating
  logic [6:0] idle_ff;
  logic [6:0] nxt_idle;
  always_comb begin
    nxt_idle = idle_ff;
    if (data_en) nxt_idle = 7'h00;
    else if (idle_ff != 7'h7f) nxt_idle = idle_ff + 7'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_ff <= 7'h00;
    else idle_ff <= nxt_idle;
  end
  chk_clk_period: assert property ($changed(tx_clk_p) |=> $stable(tx_clk_p) [*3] ##1 $changed(tx_clk_p))
    else $error("forwarded clock half period is not four cycles");
  chk_data_on_edge: assert property ($changed(tx_data_p) |-> $changed(tx_clk_p))
    else $error("lane changed away from a clock edge");
  chk_pair_invert: assert property (tx_clk_n == !tx_clk_p && tx_data_n == ~tx_data_p)
    else $error("differential pair not inverted");
  chk_lanes_same: assert property (tx_data_p == '0 || tx_data_p == '1)
    else $error("lanes carry different bits");
  chk_disabled_quiet: assert property (idle_ff >= 7'h64 |-> tx_data_p == '0 && !training_done && !data_lock)
    else $error("activity while generation is disabled");
  chk_lock_trained: assert property (data_lock |-> training_done || $past(training_done))
    else $error("data lock without training done");
  chk_lock_late: assert property ($rose(data_lock) |-> $past(training_done, 28))
    else $error("data lock rose before a full word was checked");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_unmapped_err: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  cov_trained: cover property ($rose(training_done));
  cov_locked: cover property ($rose(data_lock));
  cov_irq: cover property ($rose(irq));
  cov_err: cover property (pslverr);
endmodule
bind lvds_link_align lvds_link_align_chk #(.LANES(LANES)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .data_en(data_en), .rx_clk_p(rx_clk_p), .rx_data_p(rx_data_p), .tx_clk_p(tx_clk_p),
  .tx_clk_n(tx_clk_n), .tx_data_p(tx_data_p), .tx_data_n(tx_data_n), .training_done(training_done),
  .data_lock(data_lock), .irq(irq));
`default_nettype wire

// ===== sim/lvds_link_align_bench.sv
// self-checking loopback bench for the 7:1 link alignment block
`timescale 1ns/10ps
`default_nettype none
module lvds_link_align_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic data_en = 1'b1;
  logic flip = 1'b0;
  logic rx_clk_p;
  logic [3:0] rx_data_p;
  logic [31:0] prdata;
  logic pready, pslverr, tx_clk_p, tx_clk_n, training_done, data_lock, irq;
  logic [3:0] tx_data_p;
  logic [3:0] tx_data_n;
  logic [31:0] rdata;
  logic rerr;
  logic [7:0] mon_sh = 8'h00;
  logic mon_clk = 1'b0;
  logic seen_phase = 1'b0;
  logic seen_word = 1'b0;
  int num_errors = 0;
  int checked = 0;
  always #12.5 pclk = ~pclk;
  lvds_link_align uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_en(data_en),
    .rx_clk_p(rx_clk_p), .rx_data_p(rx_data_p), .tx_clk_p(tx_clk_p), .tx_clk_n(tx_clk_n),
    .tx_data_p(tx_data_p), .tx_data_n(tx_data_n), .training_done(training_done), .data_lock(data_lock),
    .irq(irq));
  link_peer #(.LANES(4)) peer (.tx_clk(tx_clk_p), .tx_data(tx_data_p), .flip(flip), .rx_clk(rx_clk_p),
    .rx_data(rx_data_p));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // lane 0 bits taken at both edges of the forwarded clock
  always @(posedge pclk) begin
    if (tx_clk_p !== mon_clk) begin
      mon_sh <= {mon_sh[6:0], tx_data_p[0]};
      if (mon_sh[6:0] == link_align_pkg::PHASE_PATTERN) seen_phase <= 1'b1;
      // a one, six zeros, a one: the word pattern stream makes it before the counter stream can
      if (mon_sh == 8'h81 && !seen_word) begin
        seen_word <= 1'b1;
        chk(32'(seen_phase), 32'h1);
      end
    end
    mon_clk <= tx_clk_p;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // one idle edge lets register updates reach irq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
  endtask
  task automatic wt(input logic lock, input logic v);
    int n;
    n = 0;
    while ((lock ? data_lock : training_done) !== v && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if ((lock ? data_lock : training_done) !== v) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic t_reset();
    chk({tx_data_n, tx_data_p, 3'h0, pready}, 32'h0000_0f01);
    presetn <= 1'b1;
    rd(link_align_pkg::CTRL_OFF);
    chk(rdata, 32'h0000_0001);
    rd(link_align_pkg::INT_MASK_OFF);
    chk(rdata, 32'h0000_0000);
    rd(link_align_pkg::INT_STATUS_OFF);
    chk(rdata, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_train();
    wt(1'b0, 1'b1);
    rd(link_align_pkg::STATUS_OFF);
    chk(rdata[2:0], 3'h7);
    chk(32'(seen_word), 32'h1);
    wt(1'b1, 1'b1);
    rd(link_align_pkg::STATUS_OFF);
    chk(rdata[3:0], 4'hf);
    rd(link_align_pkg::INT_STATUS_OFF);
    chk(rdata[2:0], 3'h3);
    chk(irq, 1'b0);
    $display("test train done");
  endtask
  task automatic t_irq();
    wr(link_align_pkg::INT_MASK_OFF, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(link_align_pkg::INT_STATUS_OFF, 32'h0000_0001);
    chk(irq, 1'b0);
    rd(link_align_pkg::INT_STATUS_OFF);
    chk(rdata[2:0], 3'h2);
    wr(link_align_pkg::INT_MASK_OFF, 32'h0000_0004);
    chk(irq, 1'b0);
    $display("test irq done");
  endtask
  task automatic t_disable();
    data_en <= 1'b0;
    repeat (200) @(posedge pclk);
    chk({training_done, data_lock, tx_data_p}, 32'h0000_0000);
    chk(irq, 1'b1);
    rd(link_align_pkg::INT_STATUS_OFF);
    chk(rdata[2:0], 3'h6);
    wr(link_align_pkg::INT_STATUS_OFF, 32'h0000_0007);
    chk(irq, 1'b0);
    data_en <= 1'b1;
    wt(1'b0, 1'b1);
    wt(1'b1, 1'b1);
    $display("test disable done");
  endtask
  task automatic t_corrupt();
    flip <= 1'b1;
    wt(1'b1, 1'b0);
    rd(link_align_pkg::MISMATCH_OFF);
    chk(32'(rdata[15:0] != 16'h0000), 32'h1);
    chk(irq, 1'b1);
    flip <= 1'b0;
    wt(1'b1, 1'b1);
    $display("test corrupt done");
  endtask
  task automatic t_ctrl();
    // retrain alone, with generation left on, must drop and rebuild training
    wr(link_align_pkg::CTRL_OFF, 32'h0000_0003);
    wt(1'b0, 1'b0);
    wt(1'b0, 1'b1);
    wr(link_align_pkg::CTRL_OFF, 32'h0000_0000);
    wt(1'b0, 1'b0);
    rd(link_align_pkg::CTRL_OFF);
    chk(rdata, 32'h0000_0000);
    wr(link_align_pkg::CTRL_OFF, 32'h0000_0003);
    rd(link_align_pkg::CTRL_OFF);
    chk(rdata, 32'h0000_0001);
    wt(1'b0, 1'b1);
    wt(1'b1, 1'b1);
    $display("test ctrl done");
  endtask
  task automatic t_apb();
    rd(8'h14);
    chk(rdata, 32'h0000_0000);
    chk(rerr, 1'b1);
    wr(8'h14, 32'hffff_ffff);
    chk(rerr, 1'b1);
    wr(link_align_pkg::STATUS_OFF, 32'hffff_ffff);
    rd(link_align_pkg::STATUS_OFF);
    chk({rerr, rdata[3:0]}, 5'h0f);
    $display("test apb done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    t_reset();
    t_train();
    t_irq();
    t_disable();
    t_corrupt();
    t_ctrl();
    t_apb();
    finish_test();
  end
endmodule
`default_nettype wire
